// file: design/pump_regs_pkg.sv
// Purpose: Shared constants and types for the first loop pump control registers
// Assumes: Byte-wide register port with 8-bit addresses
// Notes: Currents are expressed in units of 12.5 uA (one offset step)
package pump_regs_pkg;

    localparam logic [7:0] addr_current_ctrl = 8'h1c;
    localparam logic [7:0] addr_polarity_offset = 8'h1d;

    // Field positions, first register
    localparam int pos_power_down = 7;
    localparam int pos_reserved = 6;
    localparam int pos_sink_enable = 5;
    localparam int pos_step_doubler = 4;
    // Field positions, second register
    localparam int pos_polarity = 7;
    localparam int pos_force_mid = 6;

    // Reset values
    localparam logic rst_power_down = 1'b0;
    localparam logic rst_sink_enable = 1'b1;
    localparam logic rst_step_doubler = 1'b1;
    localparam logic [3:0] rst_gain_code = 4'h0;
    localparam logic rst_polarity = 1'b0;
    localparam logic rst_force_mid = 1'b1;
    localparam logic [5:0] rst_offset_code = 6'h00;

    // Pump current figures in 12.5 uA units
    localparam logic [8:0] cur_unit_100ua = 9'h008;
    localparam logic [8:0] cur_base_1600ua = 9'h080;
    localparam logic [8:0] cur_max_3ma = 9'h0f0;

    typedef struct packed {
        logic pump_power_down;
        logic sink_current_enable;
        logic step_doubler;
        logic [3:0] pump_gain_code;
        logic tuning_polarity;
        logic force_mid_voltage;
        logic [5:0] offset_current_code;
    } pump_cfg_type;

    typedef struct packed {
        logic wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_wr_type;

endpackage

// file: design/pump_current_calc.sv
// Purpose: Pump and offset current figures derived from the configuration
// Assumes: Configuration is static between writes
// Notes: Outputs in 12.5 uA units, registered
`timescale 1ns/1ps
module pump_current_calc
    import pump_regs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Configuration
    input wire pump_regs_pkg::pump_cfg_type cfg_i,
    // Derived currents
    output logic [8:0] pump_current_o,
    output logic [5:0] offset_current_o
);

    typedef struct packed {
        logic [8:0] pump;
        logic [5:0] offset;
    } calc_state_type;

    calc_state_type state_ff;
    calc_state_type nxt_state;

    always_comb
    begin
        nxt_state = state_ff;
        if (cfg_i.step_doubler)
        begin
            // Top gain bit has no weight in double steps [R5]
            nxt_state.pump = cur_base_1600ua
                + 9'({6'h00, cfg_i.pump_gain_code[2:0]} * 2 * cur_unit_100ua); // [R5]
        end
        else
        begin
            nxt_state.pump = 9'({5'h00, cfg_i.pump_gain_code} * cur_unit_100ua); // [R4]
        end
        if (nxt_state.pump > cur_max_3ma)
        begin
            nxt_state.pump = cur_max_3ma; // [R5]
        end
        // Weights 16,8,8,4,2,1 steps of 12.5 uA [R9]
        nxt_state.offset = 6'({1'b0, cfg_i.offset_current_code[5], 4'h0}
            + {2'b00, cfg_i.offset_current_code[4], 3'h0}
            + {2'b00, cfg_i.offset_current_code[3], 3'h0}
            + {3'h0, cfg_i.offset_current_code[2:0]});
        if (cfg_i.pump_power_down)
        begin
            nxt_state = '0; // [R1]
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            state_ff <= '0;
        else
            state_ff <= nxt_state;
    end

    assign pump_current_o = state_ff.pump;
    assign offset_current_o = state_ff.offset;

endmodule

// file: design/first_loop_pump_control_regs.sv
// Purpose: Configuration registers for the first loop charge pump
// Assumes: Byte writes and reads arrive synchronous to core_clk_i
// Notes: Outputs are static control levels for the analog pump
//
// Overview of operation
// R1 - Bit 7 of the first register powers the pump down when 1 and resets to 0.
// R2 - Bit 5 of the first register enables equal sink current when 1 and resets to 1.
// R3 - Bit 4 of the first register selects double-size gain steps when 1 and resets to 1.
// R4 - Bits 3 to 0 of the first register are the gain code, reset 0, weighted 800/400/200/100 uA.
// R5 - With double steps the current is 1600 uA plus bits 2 to 0 at 800/400/200 uA, max 3 mA.
// R6 - Bit 7 of the second register selects negative tuning polarity when 1 and resets to 0.
// R7 - Bit 6 of the second register holds the tuning output at mid supply when 1, reset 1.
// R8 - Software must clear the force bit after startup so the loop can lock.
// R9 - Bits 5 to 0 of the second register are the offset code, reset 0, 200 down to 12.5 uA.
// R10 - Reserved bit 6 of the first register ignores writes and reads as zero.
`timescale 1ns/1ps
module first_loop_pump_control_regs
    import pump_regs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Register port
    input wire pump_regs_pkg::reg_wr_type wr_i,
    input wire logic [7:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    // Pump controls
    output pump_regs_pkg::pump_cfg_type cfg_o,
    output logic pump_enable_o,
    output logic sink_enable_o,
    output logic tuning_negative_o,
    output logic hold_mid_supply_o,
    // Derived currents, 12.5 uA units
    output logic [8:0] pump_current_o,
    output logic [5:0] offset_current_o
);

    typedef struct packed {
        pump_cfg_type cfg;
        logic [7:0] rd_data;
    } regs_state_type;

    localparam pump_cfg_type cfg_reset = '{
        pump_power_down: rst_power_down,
        sink_current_enable: rst_sink_enable,
        step_doubler: rst_step_doubler,
        pump_gain_code: rst_gain_code,
        tuning_polarity: rst_polarity,
        force_mid_voltage: rst_force_mid,
        offset_current_code: rst_offset_code
    };

    regs_state_type state_ff;
    regs_state_type nxt_state;

    ////////////////////////////////////////////////////////////////////////

    function automatic logic [7:0] read_reg(input pump_cfg_type c, input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        if (a == addr_current_ctrl)
        begin
            d[pos_power_down] = c.pump_power_down;
            d[pos_reserved] = 1'b0; // [R10]
            d[pos_sink_enable] = c.sink_current_enable;
            d[pos_step_doubler] = c.step_doubler;
            d[3:0] = c.pump_gain_code;
        end
        else if (a == addr_polarity_offset)
        begin
            d[pos_polarity] = c.tuning_polarity;
            d[pos_force_mid] = c.force_mid_voltage;
            d[5:0] = c.offset_current_code;
        end
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        nxt_state = state_ff;
        if (wr_i.wr_en && wr_i.addr == addr_current_ctrl)
        begin
            nxt_state.cfg.pump_power_down = wr_i.wdata[pos_power_down]; // [R1]
            nxt_state.cfg.sink_current_enable = wr_i.wdata[pos_sink_enable]; // [R2]
            nxt_state.cfg.step_doubler = wr_i.wdata[pos_step_doubler]; // [R3]
            nxt_state.cfg.pump_gain_code = wr_i.wdata[3:0]; // [R4]
            // Bit 6 is dropped here [R10]
        end
        if (wr_i.wr_en && wr_i.addr == addr_polarity_offset)
        begin
            nxt_state.cfg.tuning_polarity = wr_i.wdata[pos_polarity]; // [R6]
            // Software clears this to let the loop lock
            nxt_state.cfg.force_mid_voltage = wr_i.wdata[pos_force_mid]; // [R7]
            nxt_state.cfg.offset_current_code = wr_i.wdata[5:0]; // [R9]
        end
        // Read shows the value before a same-cycle write
        nxt_state.rd_data = read_reg(state_ff.cfg, rd_addr_i);
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            state_ff.cfg <= cfg_reset;
            state_ff.rd_data <= 8'h00;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    assign rd_data_o = state_ff.rd_data;
    assign cfg_o = state_ff.cfg;
    assign pump_enable_o = ~state_ff.cfg.pump_power_down; // [R1]
    // Sink follows the enable but dies with power-down [R2]
    assign sink_enable_o = state_ff.cfg.sink_current_enable & ~state_ff.cfg.pump_power_down;
    assign tuning_negative_o = state_ff.cfg.tuning_polarity; // [R6]
    assign hold_mid_supply_o = state_ff.cfg.force_mid_voltage; // [R7]

    pump_current_calc u_calc (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .cfg_i(state_ff.cfg),
        .pump_current_o(pump_current_o),
        .offset_current_o(offset_current_o)
    );

endmodule

// file: testbench/pump_regs_properties.sv
// Purpose: Port assertions for the pump control registers
// Assumes: One clock, synchronous active-high reset
// Notes: Currents in 12.5 uA units
`timescale 1ns/1ps
module pump_regs_properties
    import pump_regs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Register port
    input wire pump_regs_pkg::reg_wr_type wr_i,
    input wire logic [7:0] rd_addr_i,
    input wire logic [7:0] rd_data_o,
    // Pump controls
    input wire pump_regs_pkg::pump_cfg_type cfg_o,
    input wire logic pump_enable_o,
    input wire logic sink_enable_o,
    input wire logic tuning_negative_o,
    input wire logic hold_mid_supply_o,
    input wire logic [8:0] pump_current_o,
    input wire logic [5:0] offset_current_o
);
    logic [5:0] off_exp;
    logic [5:0] oc;
    assign oc = cfg_o.offset_current_code;
    // Bits 4 and 3 share one weight, so they can carry
    assign off_exp = {1'b0, oc[5], 1'b0, oc[2:0]} + {2'h0, oc[4], 3'h0} + {2'h0, oc[3], 3'h0};
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    sequence wr_at(logic [7:0] a);
        wr_i.wr_en && wr_i.addr == a;
    endsequence
    sequence live;
        !cfg_o.pump_power_down;
    endsequence
    pd_level_a: assert property (pump_enable_o == !cfg_o.pump_power_down)
        else $error("pump enable wrong");
    sink_gate_a: assert property (sink_enable_o == (cfg_o.sink_current_enable && !cfg_o.pump_power_down))
        else $error("sink enable wrong");
    hold_mid_a: assert property (hold_mid_supply_o == cfg_o.force_mid_voltage)
        else $error("hold mid wrong");
    tuning_neg_a: assert property (tuning_negative_o == cfg_o.tuning_polarity)
        else $error("polarity wrong");
    wr_first_a: assert property (wr_at(8'h1c) |=> {cfg_o.pump_power_down, cfg_o.sink_current_enable,
        cfg_o.step_doubler, cfg_o.pump_gain_code} == $past({wr_i.wdata[7], wr_i.wdata[5:0]}))
        else $error("first register write wrong");
    wr_second_a: assert property (wr_at(8'h1d) |=> {cfg_o.tuning_polarity, cfg_o.force_mid_voltage,
        cfg_o.offset_current_code} == $past(wr_i.wdata))
        else $error("second register write wrong");
    rsv_read_a: assert property (rd_addr_i == 8'h1c |=> !rd_data_o[6])
        else $error("reserved bit read one");
    x1_cur_a: assert property (live and !cfg_o.step_doubler |=>
        pump_current_o == {2'h0, $past(cfg_o.pump_gain_code), 3'h0})
        else $error("single step current wrong");
    x2_cur_a: assert property (live and cfg_o.step_doubler |=>
        pump_current_o == {2'h1, $past(cfg_o.pump_gain_code[2:0]), 4'h0})
        else $error("double step current wrong");
    off_cur_a: assert property (live |=> offset_current_o == $past(off_exp))
        else $error("offset current wrong");
    pd_zero_a: assert property (cfg_o.pump_power_down |=> pump_current_o == 9'h000 && !offset_current_o)
        else $error("currents live in power down");
endmodule
bind first_loop_pump_control_regs pump_regs_properties chk_u (.*);

// file: testbench/test_first_loop_pump_control_regs.sv
// Purpose: Self-checking bench for the pump control registers
// Assumes: Write pulse taken next edge, results settled two edges on
// Notes: Model held in plain integers
`timescale 1ns/1ps
module test_first_loop_pump_control_regs;
    import pump_regs_pkg::*;
    logic core_clk_i;
    logic srst_i = 1'b1;
    reg_wr_type wr_i = '0;
    logic [7:0] rd_addr_i = 8'h00;
    logic [7:0] rd_data_o;
    pump_cfg_type cfg_o;
    logic pump_enable_o, sink_enable_o, tuning_negative_o, hold_mid_supply_o;
    logic [8:0] pump_current_o;
    logic [5:0] offset_current_o;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    int m1c = 'h30;
    int m1d = 'h40;
    first_loop_pump_control_regs dut_u (.*);
    ////////////////////////////////////////////////////////////////
    initial
    begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            miscompares++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input int exp);
        check_count++;
        if (got !== 16'(exp))
        begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, got, 16'(exp));
        end
    endtask
    // Unmapped addresses one time in four
    function automatic logic [7:0] pick();
        return ($urandom % 4 == 0) ? 8'($urandom) : 8'h1c + 8'($urandom % 2);
    endfunction
    task automatic op(input logic [7:0] a, input logic [7:0] d, input logic [7:0] ra);
        int g;
        int o;
        @(posedge core_clk_i);
        wr_i <= '{1'b1, a, d};
        rd_addr_i <= ra;
        @(posedge core_clk_i);
        wr_i.wr_en <= 1'b0;
        if (a == 8'h1c) m1c = d & 'hbf;
        if (a == 8'h1d) m1d = d;
        @(posedge core_clk_i);
        #1;
        g = m1c[7] ? 0 : m1c[4] ? 128 + 16 * (m1c & 7) : 8 * (m1c & 15);
        o = m1d & 63;
        o = m1c[7] ? 0 : 16 * o[5] + 8 * o[4] + 8 * o[3] + (o & 7);
        chk(rd_data_o, ra == 'h1c ? m1c : ra == 'h1d ? m1d : 0);
        chk(pump_current_o, g);
        chk(offset_current_o, o);
        chk(cfg_o, {m1c[7], m1c[5:0], m1d[7:0]});
        chk({pump_enable_o, sink_enable_o, tuning_negative_o, hold_mid_supply_o},
            {!m1c[7], m1c[5] & !m1c[7], m1d[7], m1d[6]});
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(17036));
        repeat (16) @(posedge core_clk_i);
        srst_i <= 1'b0;
        op(8'h55, 8'hff, 8'h1c);
        op(8'h00, 8'h00, 8'h1d);
        op(8'h1d, 8'h00, 8'h42);
        op(8'h1c, 8'hff, 8'h1c);
        repeat (300) op(pick(), 8'($urandom), pick());
        // Mid-run reset must restore every default over random contents
        @(posedge core_clk_i);
        srst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        srst_i <= 1'b0;
        m1c = 'h30;
        m1d = 'h40;
        op(8'h42, 8'h00, 8'h1d);
        op(8'h1d, 8'h80, 8'h1c);
        finish_test();
    end
endmodule
